// ---- design/ipdc_regs.svh ----
// register offsets, field positions and reset values of the interpolation datapath
`ifndef IPDC_REGS_SVH
`define IPDC_REGS_SVH

// register offsets on the 8-bit configuration port
`define IPDC_OFS_CFG_A    8'h1c
`define IPDC_OFS_CFG_B    8'h1d
`define IPDC_OFS_CFG_C    8'h1e
`define IPDC_OFS_FTW0     8'h30
`define IPDC_OFS_FTW1     8'h31
`define IPDC_OFS_FTW2     8'h32
`define IPDC_OFS_FTW3     8'h33
`define IPDC_OFS_UPD      8'h36
`define IPDC_OFS_STAT     8'h3f

// fields of interp_stage_cfg_a
`define IPDC_A_MODE_MSB   1
`define IPDC_A_MODE_LSB   0
`define IPDC_A_BYP_BIT    2
`define IPDC_A_PREMOD_BIT 3
`define IPDC_A_NCO_BIT    4
// fields of interp_stage_cfg_b and interp_stage_cfg_c
`define IPDC_BC_MODE_MSB  2
`define IPDC_BC_MODE_LSB  0
`define IPDC_BC_BYP_BIT   6
// field of carrier_word_update
`define IPDC_UPD_BIT      0

// reset values
`define IPDC_RST_CFG      8'h00
`define IPDC_RST_FTW      32'h0000_0000

// carrier oscillator phase width, a full turn is 2^32
`define IPDC_PHASE_BITS   32
// quarter-turn in sine table steps (16 steps per turn)
`define IPDC_QUARTER      4'h4

`endif

// ---- design/ipdc_pkg.sv ----
// types shared by the interpolation datapath
package ipdc_pkg;

   // one complex sample, i and q in two's complement
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } ipdc_iq_t;

   // one access on the configuration port
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       re;
   } ipdc_cfg_req_t;

endpackage

// ---- design/ipdc_interp.sv ----
// interpolation datapath: input fifo, three half-band stages, carrier oscillator, registers
//
// Behaviour
// - new tuning word waits for update bit rise
// - other configuration writes act at once
// - carrier frequency is word over 2^32 times rate
// - output rate is 2^stages times input rate
// - three mode fields in three consecutive registers
// - factor 8, 4, 2 use three, two, one stages
// - premodulation shifts input by half input rate when the first stage runs in mode 1 or 3
// - 2x passes 80 percent complex bandwidth
// - 8x passes 50 to 80 percent bandwidth
// - 4x may run on second and third stages
// - oscillator runs at first stage output rate
// - later stages shift centre by quarter input rate
// - quadrature carrier mixed and summed into i, q
`timescale 1ns/1ns
`include "ipdc_regs.svh"

// sample fifo, flip-flop storage, depth a power of two
module ipdc_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 16
) (
   input  wire logic         clk_i,      // clock
   input  wire logic         rstn_i,     // async reset, low
   input  wire logic         ce_i,       // clock enable
   input  wire logic         wr_valid_i, // write request
   input  wire logic [W-1:0] wr_data_i,  // write data
   output logic              wr_ready_o, // room for a word
   output logic              rd_valid_o, // word available
   output logic [W-1:0]      rd_data_o,  // head word
   input  wire logic         rd_ready_i, // drain takes head
   output logic [4:0]        count_o     // fill level, saturates at 31
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem_reg [DEPTH];      // storage
   logic [AW-1:0] wp_reg, wp_next;      // write index
   logic [AW-1:0] rp_reg, rp_next;      // read index
   logic [CW-1:0] cnt_reg, cnt_next;    // words held
   logic          rdy_reg, rdy_next;    // not full
   logic          val_reg, val_next;    // not empty
   logic          push, pop;            // accepted moves

   // flags are flops so that ready reaches the source without a comb path
   assign push = ce_i & wr_valid_i & rdy_reg;
   assign pop  = ce_i & rd_ready_i & val_reg;

   // pointer and level bookkeeping
   always_comb begin
      wp_next  = push ? wp_reg + AW'(1) : wp_reg;
      rp_next  = pop ? rp_reg + AW'(1) : rp_reg;
      cnt_next = cnt_reg + CW'(push) - CW'(pop);
      rdy_next = cnt_next != CW'(DEPTH);
      val_next = cnt_next != '0;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
         rdy_reg <= 1'b1;
         val_reg <= 1'b0;
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
         val_reg <= val_next;
      end
   end

   // storage needs no reset, the level guards every read
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wp_reg] <= wr_data_i;
      end
   end

   assign wr_ready_o = rdy_reg;
   assign rd_valid_o = val_reg;
   assign rd_data_o  = mem_reg[rp_reg];
   assign count_o    = (cnt_reg > CW'(31)) ? 5'h1f : 5'(cnt_reg);
endmodule // ipdc_fifo

// datapath top
module ipdc_interp #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic                    clk_i,       // 250 MHz clock
   input  wire logic                    rstn_i,      // async reset, low
   input  wire logic                    ce_i,        // clock enable
   input  wire ipdc_pkg::ipdc_cfg_req_t cfg_i,       // register access
   output logic [7:0]                   cfg_rdata_o, // read data
   input  wire ipdc_pkg::ipdc_iq_t      in_i,        // input sample
   input  wire logic                    in_valid_i,  // input offered
   output logic                         in_ready_o,  // fifo has room
   output ipdc_pkg::ipdc_iq_t           out_o,       // output sample
   output logic                         out_valid_o  // output strobe
);
   import ipdc_pkg::*;

   // bits of the cycle counter below w are all zero
   function automatic logic lowz(input logic [2:0] c, input logic [1:0] w);
      logic ok;
      ok = 1'b1;
      for (int b = 0; b < 3; b++) begin
         if (b < int'(w) && c[b]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // cosine of k * 22.5 degrees, k 0..4, q15
   function automatic logic signed [15:0] lut(input logic [2:0] k);
      case (k)
         3'h0:    return 16'sh7fff;
         3'h1:    return 16'sh7642;
         3'h2:    return 16'sh5a82;
         3'h3:    return 16'sh30fc;
         default: return 16'sh0000;
      endcase
   endfunction

   // cosine over a full turn of 16 steps, folded onto one quadrant
   function automatic logic signed [15:0] cosq(input logic [3:0] p);
      logic [2:0]         k;
      logic signed [15:0] m;
      k = p[2] ? 3'h4 - {1'b0, p[1:0]} : {1'b0, p[1:0]};
      m = lut(k);
      return (p[3] ^ p[2]) ? -m : m;
   endfunction

   // complex rotation; the truncation drops one lsb, no saturation
   function automatic ipdc_iq_t rotate(input ipdc_iq_t s, input logic [3:0] p);
      logic signed [15:0] c, sn;
      logic signed [32:0] ti, tq;
      ipdc_iq_t           r;
      // phase zero passes exactly; the q15 gain of 0x7fff would shave an lsb
      if (p == 4'h0) begin
         return s;
      end
      c  = cosq(p);
      sn = cosq(p - `IPDC_QUARTER);
      ti = s.i * c - s.q * sn;
      tq = s.i * sn + s.q * c;
      r.i = ti[30:15];
      r.q = tq[30:15];
      return r;
   endfunction

   // mean of two samples: a two-tap stand-in for the half-band kernel
   function automatic ipdc_iq_t avg(input ipdc_iq_t a, input ipdc_iq_t b);
      logic signed [16:0] si, sq;
      ipdc_iq_t           r;
      si  = (17'(a.i) + 17'(b.i)) >>> 1;
      sq  = (17'(a.q) + 17'(b.q)) >>> 1;
      r.i = si[15:0];
      r.q = sq[15:0];
      return r;
   endfunction

   // configuration registers
   logic [7:0]  cfg_a_reg, cfg_a_next;   // first stage mode, bypass, premod, nco
   logic [7:0]  cfg_b_reg, cfg_b_next;   // second stage field, bypass
   logic [7:0]  cfg_c_reg, cfg_c_next;   // third stage field, bypass
   logic [31:0] ftw_sh_reg, ftw_sh_next; // written tuning word, not yet live
   logic [31:0] ftw_reg, ftw_next;       // live carrier_tuning_word
   logic [7:0]  upd_reg, upd_next;       // carrier_word_update
   logic [7:0]  rdata_reg, rdata_next;   // read data
   logic        upd_rise;                // update bit goes 0 to 1
   logic        wr;                      // write this cycle
   logic [4:0]  fifo_cnt;                // fifo level

   // datapath control
   logic [2:0]  en;                      // stage enabled
   logic [1:0]  nact;                    // active stages
   logic [1:0]  sh [3];                  // log2 of output period per stage
   logic [2:0]  s_in, s_out;             // stage load and emit strobes
   logic [2:0]  cnt_reg, cnt_next;       // output cycle counter
   logic        take, adv, pop;          // input slot, advance, fifo pop
   logic        fifo_valid;              // fifo head valid
   ipdc_iq_t    fifo_data;               // fifo head
   logic        pm_on;                   // premodulation active
   logic        pm_reg, pm_next;         // premod sign
   logic [31:0] acc_reg, acc_next;       // oscillator phase
   logic        nco_tick;                // oscillator clock
   ipdc_iq_t    st_in [3];               // stage inputs
   ipdc_iq_t    st_out [3];              // stage outputs
   ipdc_iq_t    out_reg, out_next;       // output sample
   logic        ov_reg, ov_next;         // output valid

   assign wr       = ce_i & cfg_i.we;
   assign upd_rise = wr && cfg_i.addr == `IPDC_OFS_UPD && cfg_i.wdata[`IPDC_UPD_BIT]
                     && !upd_reg[`IPDC_UPD_BIT];

   // register writes and reads
   always_comb begin
      cfg_a_next  = cfg_a_reg;
      cfg_b_next  = cfg_b_reg;
      cfg_c_next  = cfg_c_reg;
      ftw_sh_next = ftw_sh_reg;
      upd_next    = upd_reg;
      rdata_next  = rdata_reg;
      // the live word only moves on an update rise
      ftw_next    = upd_rise ? ftw_sh_reg : ftw_reg;
      if (wr) begin
         // stage fields act from the next cycle, no strobe
         case (cfg_i.addr)
            `IPDC_OFS_CFG_A: cfg_a_next        = cfg_i.wdata;
            `IPDC_OFS_CFG_B: cfg_b_next        = cfg_i.wdata;
            `IPDC_OFS_CFG_C: cfg_c_next        = cfg_i.wdata;
            `IPDC_OFS_FTW0:  ftw_sh_next[7:0]   = cfg_i.wdata;
            `IPDC_OFS_FTW1:  ftw_sh_next[15:8]  = cfg_i.wdata;
            `IPDC_OFS_FTW2:  ftw_sh_next[23:16] = cfg_i.wdata;
            `IPDC_OFS_FTW3:  ftw_sh_next[31:24] = cfg_i.wdata;
            // software must write 0 before the next 1
            `IPDC_OFS_UPD:   upd_next          = cfg_i.wdata;
            default:         ;
         endcase
      end
      if (ce_i && cfg_i.re) begin
         case (cfg_i.addr)
            `IPDC_OFS_CFG_A: rdata_next = cfg_a_reg;
            `IPDC_OFS_CFG_B: rdata_next = cfg_b_reg;
            `IPDC_OFS_CFG_C: rdata_next = cfg_c_reg;
            `IPDC_OFS_FTW0:  rdata_next = ftw_sh_reg[7:0];
            `IPDC_OFS_FTW1:  rdata_next = ftw_sh_reg[15:8];
            `IPDC_OFS_FTW2:  rdata_next = ftw_sh_reg[23:16];
            `IPDC_OFS_FTW3:  rdata_next = ftw_sh_reg[31:24];
            `IPDC_OFS_UPD:   rdata_next = upd_reg;
            `IPDC_OFS_STAT:  rdata_next = {1'b0, nact, fifo_cnt};
            default:         rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_a_reg  <= `IPDC_RST_CFG;
         cfg_b_reg  <= `IPDC_RST_CFG;
         cfg_c_reg  <= `IPDC_RST_CFG;
         ftw_sh_reg <= `IPDC_RST_FTW;
         ftw_reg    <= `IPDC_RST_FTW;
         upd_reg    <= `IPDC_RST_CFG;
         rdata_reg  <= 8'h00;
      end else begin
         cfg_a_reg  <= cfg_a_next;
         cfg_b_reg  <= cfg_b_next;
         cfg_c_reg  <= cfg_c_next;
         ftw_sh_reg <= ftw_sh_next;
         ftw_reg    <= ftw_next;
         upd_reg    <= upd_next;
         rdata_reg  <= rdata_next;
      end
   end

   // stage enables; factor = 2^nact, 4x may skip the first stage
   assign en   = {~cfg_c_reg[`IPDC_BC_BYP_BIT], ~cfg_b_reg[`IPDC_BC_BYP_BIT],
                  ~cfg_a_reg[`IPDC_A_BYP_BIT]};
   assign nact = 2'(en[0]) + 2'(en[1]) + 2'(en[2]);
   assign take = lowz(cnt_reg, nact);
   // a starved fifo freezes the whole chain rather than emit stale data
   assign adv  = ce_i & (~take | fifo_valid);
   assign pop  = adv & take;

   ipdc_fifo #(
      .W     ($bits(ipdc_iq_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i      (clk_i),
      .rstn_i     (rstn_i),
      .ce_i       (ce_i),
      .wr_valid_i (in_valid_i),
      .wr_data_i  (in_i),
      .wr_ready_o (in_ready_o),
      .rd_valid_o (fifo_valid),
      .rd_data_o  (fifo_data),
      .rd_ready_i (pop),
      .count_o    (fifo_cnt)
   );

   // premod flips sign every input sample, a shift by half the input rate
   assign pm_on = en[0] & cfg_a_reg[`IPDC_A_PREMOD_BIT] & cfg_a_reg[`IPDC_A_MODE_LSB];
   assign st_in[0] = (pm_on && pm_reg) ? ipdc_iq_t'{-fifo_data.i, -fifo_data.q} : fifo_data;
   // oscillator runs at the first stage output rate
   assign nco_tick = adv & s_out[0];
   // quadrature carrier, i and q mixed and summed back per sample
   assign st_in[1] = cfg_a_reg[`IPDC_A_NCO_BIT] ? rotate(st_out[0], acc_reg[31:28])
                     : st_out[0];
   assign st_in[2] = st_out[1];

   // oscillator phase and premod sign
   always_comb begin
      pm_next  = (pop && pm_on) ? ~pm_reg : pm_reg;
      acc_next = nco_tick ? acc_reg + ftw_reg : acc_reg;
      cnt_next = adv ? cnt_reg + 3'h1 : cnt_reg;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pm_reg  <= 1'b0;
         acc_reg <= `IPDC_RST_FTW;
         cnt_reg <= 3'h0;
      end else begin
         pm_reg  <= pm_next;
         acc_reg <= acc_next;
         cnt_reg <= cnt_next;
      end
   end

   // three stages; each doubles the rate; per output the first rotates by mode * 90 deg, the later two by mode * 45 deg
   for (genvar k = 0; k < 3; k++) begin : g_stage
      ipdc_iq_t   cur_reg, cur_next;     // newest input
      ipdc_iq_t   prv_reg, prv_next;     // previous input
      logic [2:0] ph_reg, ph_next;       // rotation phase, 45 deg units
      logic [2:0] step;                  // phase step per output
      logic [1:0] dep;                   // enabled stages up to this one
      ipdc_iq_t   raw;                   // interpolated sample

      if (k == 0) begin : g_first
         // first stage mode m centres at m * half its input rate
         assign step = {cfg_a_reg[`IPDC_A_MODE_MSB:`IPDC_A_MODE_LSB], 1'b0};
         assign dep  = 2'(en[0]);
      end else begin : g_later
         // only the low copy of the repeated code is used
         assign step = (k == 1) ? cfg_b_reg[`IPDC_BC_MODE_MSB:`IPDC_BC_MODE_LSB]
                                : cfg_c_reg[`IPDC_BC_MODE_MSB:`IPDC_BC_MODE_LSB];
         assign dep  = 2'(en[0]) + 2'(en[1]) + ((k == 2) ? 2'(en[2]) : 2'h0);
      end

      assign sh[k]    = nact - dep;
      assign s_in[k]  = lowz(cnt_reg, sh[k] + 2'h1);
      assign s_out[k] = lowz(cnt_reg, sh[k]);
      // first output slot of each input period is the midpoint
      assign raw       = cnt_reg[sh[k]] ? cur_reg : avg(prv_reg, cur_reg);
      // a bypassed stage hands its input straight on
      assign st_out[k] = en[k] ? rotate(raw, {ph_reg, 1'b0}) : st_in[k];

      always_comb begin
         cur_next = cur_reg;
         prv_next = prv_reg;
         ph_next  = ph_reg;
         if (adv && en[k] && s_in[k]) begin
            prv_next = cur_reg;
            cur_next = st_in[k];
         end
         if (adv && en[k] && s_out[k]) begin
            ph_next = ph_reg + step;
         end
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            cur_reg <= '0;
            prv_reg <= '0;
            ph_reg  <= 3'h0;
         end else begin
            cur_reg <= cur_next;
            prv_reg <= prv_next;
            ph_reg  <= ph_next;
         end
      end
   end

   // one output per advanced cycle, so the output rate is the clock
   always_comb begin
      out_next = adv ? st_out[2] : out_reg;
      ov_next  = adv;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_reg <= '0;
         ov_reg  <= 1'b0;
      end else begin
         out_reg <= out_next;
         ov_reg  <= ov_next;
      end
   end

   assign out_o       = out_reg;
   assign out_valid_o = ov_reg;
   assign cfg_rdata_o = rdata_reg;

   // helper: advanced cycles between pops, voided by any config write
   logic [3:0] gap_reg;
   logic       seen_reg, dirty_reg;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gap_reg   <= 4'h0;
         seen_reg  <= 1'b0;
         dirty_reg <= 1'b0;
      end else begin
         if (adv) begin
            gap_reg <= pop ? 4'h1 : gap_reg + 4'h1;
         end
         if (pop) begin
            seen_reg <= 1'b1;
         end
         dirty_reg <= wr ? 1'b1 : (pop ? 1'b0 : dirty_reg);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   chk_ftw_hold: assert property ($changed(ftw_reg) |-> $past(upd_rise))
      else $error("live tuning word moved without update rise");
   chk_ftw_load: assert property (upd_rise |=> ftw_reg == $past(ftw_sh_reg))
      else $error("update rise did not load tuning word");
   chk_upd_sticky: assert property (!wr ##1 !wr |-> $stable(upd_reg))
      else $error("update register changed by itself");
   chk_cfg_now: assert property (wr && cfg_i.addr == `IPDC_OFS_CFG_B
      |=> cfg_b_reg == $past(cfg_i.wdata))
      else $error("stage config not applied at once");
   chk_rate_ratio: assert property (pop && seen_reg && !dirty_reg && !wr
      |-> gap_reg == (4'h1 << nact))
      else $error("input rate not output rate over factor");
   chk_nco_rate: assert property ($changed(acc_reg) |-> $past(nco_tick))
      else $error("oscillator stepped off its rate");
   chk_nco_step: assert property (nco_tick && !wr |=> acc_reg == $past(acc_reg + ftw_reg))
      else $error("oscillator step not the tuning word");
   chk_premod_flip: assert property (pop && pm_on |=> pm_reg != $past(pm_reg))
      else $error("premod sign did not alternate");
   chk_mode_step: assert property (adv && en[1] && s_out[1] && !wr
      |=> g_stage[1].ph_reg == $past(g_stage[1].ph_reg + cfg_b_reg[2:0]))
      else $error("second stage rotation step wrong");
   chk_bypass_pass: assert property (!en[1] |-> st_out[1] == st_in[1])
      else $error("bypassed stage altered sample");
   chk_out_strobe: assert property (adv |=> out_valid_o && out_o == $past(st_out[2]))
      else $error("output not taken on advance");

   cov_run_8x: cover property (nact == 2'h3 && pop ##[1:16] pop);
   cov_4x_low_power: cover property (!en[0] && en[1] && en[2] && pop);
   cov_ftw_update: cover property (upd_rise ##1 nco_tick);
   cov_fifo_full: cover property (!in_ready_o && in_valid_i);
endmodule // ipdc_interp

// ---- testbench/ipdc_src.sv ----
// upstream sample source that feeds the datapath input stream
`timescale 1ns/1ns
module ipdc_src (
   input  wire logic               clk_i,   // clock
   input  wire logic               rstn_i,  // async reset, low
   input  wire logic               en_i,    // offer samples when high
   input  wire ipdc_pkg::ipdc_iq_t data_i,  // sample to offer
   input  wire logic               ready_i, // datapath has room
   output ipdc_pkg::ipdc_iq_t      in_o,    // offered sample
   output logic                    valid_o  // offer strobe
);
   import ipdc_pkg::*;
   logic taken; // offer accepted at this edge
   logic en_s;  // enable as seen at the edge
   initial begin
      valid_o = 1'b0;
      in_o    = '0;
   end
   // sample at the edge, move just after it; ce is not seen, so the bench stops it first
   always @(posedge clk_i or negedge rstn_i) begin
      taken = valid_o & ready_i;
      en_s  = en_i;
      #1;
      if (!rstn_i) begin
         valid_o = 1'b0;
         in_o    = ~in_o;
      end else if (taken || !valid_o) begin
         valid_o = en_s;
         // an idle bus never keeps its last value
         in_o    = en_s ? data_i : ~in_o;
      end
   end
endmodule // ipdc_src

// ---- testbench/interpolation_datapath_config_test.sv ----
// self-checking bench of the interpolation datapath
`timescale 1ns/1ns
`include "ipdc_regs.svh"
module interpolation_datapath_config_test;
   import ipdc_pkg::*;
   localparam logic [31:0] K = 32'h1000_0800; // constant sample, i then q
   logic          clk, rstn, ce, src_en;      // clock, reset, enable, source on
   ipdc_cfg_req_t cfg;                        // register access
   logic [7:0]    rdata, v;                   // read data
   ipdc_iq_t      in_s, out_s;                // stream samples
   logic          in_valid, in_ready;         // input handshake
   logic          out_valid;                  // output strobe
   logic [31:0]   first;                      // first output of a window
   logic          same;                       // window outputs all equal
   int            fails, tests_run, n;        // counters

   ipdc_interp #(.FIFO_DEPTH(16)) dut (.clk_i(clk), .rstn_i(rstn), .ce_i(ce), .cfg_i(cfg),
      .cfg_rdata_o(rdata), .in_i(in_s), .in_valid_i(in_valid), .in_ready_o(in_ready),
      .out_o(out_s), .out_valid_o(out_valid));
   ipdc_src src (.clk_i(clk), .rstn_i(rstn), .en_i(src_en), .data_i(K), .ready_i(in_ready),
      .in_o(in_s), .valid_o(in_valid));

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   // one write: strobe for one taken edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk); #1;
      cfg = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk); #1;
      cfg.we = 1'b0;
   endtask
   // read into v; data is registered, so look one edge later
   task automatic rd(input logic [7:0] a);
      @(posedge clk); #1;
      cfg = '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clk); #1;
      cfg.re = 1'b0;
      @(posedge clk); #1;
      v = rdata;
   endtask
   // read and compare
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      check({24'h0, v}, {24'h0, exp});
   endtask
   // watch eight outputs after settling, compare their sameness
   task automatic win(input logic exp);
      int k, t;
      k = 0;
      t = 0;
      same = 1'b1;
      repeat (24) @(posedge clk);
      while (k < 8 && t < 400) begin
         @(posedge clk); #1;
         t++;
         if (out_valid === 1'b1) begin
            if (k == 0) first = out_s;
            else if (out_s !== first) same = 1'b0;
            k++;
         end
      end
      if (k < 8) begin
         fails++;
         $display("BAD %0t output wait ran out", $time);
         summarize;
      end
      check({31'h0, same}, {31'h0, exp});
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      src_en = 1'b0;
      fails = 0;
      tests_run = 0;
      first = '0;
      cfg = '{addr: 8'h00, wdata: 8'h00, we: 1'b0, re: 1'b0};
      repeat (10) @(posedge clk);
      check({30'h0, out_valid, in_ready}, 32'h1); // quiet stream in reset
      #1 rstn = 1'b1;
      // reset values, unmapped place, frozen clock enable
      rc(`IPDC_OFS_CFG_A, 8'h00);
      rc(`IPDC_OFS_CFG_C, 8'h00);
      rc(`IPDC_OFS_UPD, 8'h00);
      wr(8'h50, 8'h5a);
      rc(8'h50, 8'h00);
      ce = 1'b0;
      wr(`IPDC_OFS_CFG_B, 8'h55);
      ce = 1'b1;
      rc(`IPDC_OFS_CFG_B, 8'h00);
      // fill the fifo at 8x until it refuses, then drain it dry
      src_en = 1'b1;
      n = 0;
      while (in_ready !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, in_ready}, 32'h0);
      if (n >= 100) summarize;
      #1 src_en = 1'b0;
      repeat (200) @(posedge clk);
      // drained fifo, three stages active at reset
      rc(`IPDC_OFS_STAT, 8'h60);
      src_en = 1'b1;
      // factors 8, 4, 2 and all bypassed: stage count, input pace, passthrough
      for (int f = 0; f < 4; f++) begin
         wr(`IPDC_OFS_CFG_A, (f == 3) ? 8'h04 : 8'h00);
         wr(`IPDC_OFS_CFG_B, (f >= 2) ? 8'h40 : 8'h00);
         wr(`IPDC_OFS_CFG_C, (f >= 1) ? 8'h40 : 8'h00);
         rd(`IPDC_OFS_STAT);
         check({30'h0, v[6:5]}, 32'(3 - f));
         n = 0;
         repeat (64) @(posedge clk);
         repeat (256) begin
            @(posedge clk); #1;
            if (in_valid === 1'b1 && in_ready === 1'b1) n++;
         end
         check({31'h0, n >= (256 >> (3 - f)) - 1 && n <= (256 >> (3 - f)) + 1}, 32'h1);
         win(1'b1);
         check(first, K);
      end
      // every later-stage mode code at 4x; only mode 0 keeps a constant input still
      wr(`IPDC_OFS_CFG_A, 8'h00);
      for (int m = 0; m < 8; m++) begin
         wr(`IPDC_OFS_CFG_B, 8'(m * 9));
         rc(`IPDC_OFS_CFG_B, 8'(m * 9));
         win(m == 0);
      end
      // first stage modes at 2x
      wr(`IPDC_OFS_CFG_B, 8'h40);
      for (int m = 0; m < 4; m++) begin
         wr(`IPDC_OFS_CFG_A, 8'(m));
         win(m == 0);
      end
      // mode 1 with premodulation flips the sign of every second input sample
      wr(`IPDC_OFS_CFG_A, 8'h09);
      win(1'b0);
      // mid-run reset clears the stage phases left by the mode sweep
      rstn = 1'b0;
      repeat (10) @(posedge clk);
      check({30'h0, out_valid, in_ready}, 32'h1);
      #1 rstn = 1'b1;
      rc(`IPDC_OFS_CFG_A, 8'h00);
      wr(`IPDC_OFS_CFG_B, 8'h40);
      wr(`IPDC_OFS_CFG_C, 8'h40);
      // carrier word: shadowed until the update bit rises, a held 1 does nothing
      wr(`IPDC_OFS_CFG_A, 8'h10);
      wr(`IPDC_OFS_FTW3, 8'h10);
      rc(`IPDC_OFS_FTW3, 8'h10);
      win(1'b1);
      check(first, K);
      wr(`IPDC_OFS_UPD, 8'h01);
      win(1'b0);
      wr(`IPDC_OFS_FTW3, 8'h00);
      wr(`IPDC_OFS_UPD, 8'h01);
      win(1'b0);
      rc(`IPDC_OFS_UPD, 8'h01);
      wr(`IPDC_OFS_UPD, 8'h00);
      wr(`IPDC_OFS_UPD, 8'h01);
      win(1'b1);
      summarize;
   end
endmodule // interpolation_datapath_config_test
